// ==== design/flash_volatile_config_lock_regs.svh ====
`ifndef FLASH_VOLATILE_CONFIG_LOCK_REGS_SVH
`define FLASH_VOLATILE_CONFIG_LOCK_REGS_SVH

// ****************************************************************
// Command opcodes
// ****************************************************************
`define OP_LEGACY_REGISTER_WRITE 8'h01
`define OP_CONFIG_READ 8'h35
`define OP_ANY_REGISTER_READ 8'h65
`define OP_ANY_REGISTER_WRITE 8'h71
`define OP_ONETIME_AREA_PROGRAM 8'h42

// ****************************************************************
// Register addresses for the any-register commands
// ****************************************************************
`define ADDR_STATUS_ONE_NONVOLATILE 24'h000000
`define ADDR_CONFIG_ONE_NONVOLATILE 24'h000002
`define ADDR_STATUS_ONE_VOLATILE 24'h800000
`define ADDR_CONFIG_ONE_VOLATILE 24'h800002

// ****************************************************************
// One-time area and read latency
// ****************************************************************
`define ONETIME_AREA_LAST 24'h0003FF
`define ANY_READ_DUMMY_BYTES 3'h1

// ****************************************************************
// Field positions
// ****************************************************************
`define CFG_FREEZE 0
`define CFG_QUAD 1
`define CFG_PARAM 2
`define CFG_SELECT 3
`define CFG_ORIGIN 5
`define STS_BP_LO 2
`define STS_BP_HI 4
`define STS_PROG_ERR 6
`define STS_WRITE_DISABLE 7

// ****************************************************************
// Reset values
// ****************************************************************
`define WIDE_DEFAULT_RST 1'b0
`define WRITE_DISABLE_RST 1'b0
`define BP_RST 3'h0

`endif

// ==== design/flash_cfg_pkg.sv ====
package flash_cfg_pkg;

  typedef enum logic [1:0]
  {
    CMD_NONE = 2'b00,
    CMD_LEGACY_WRITE = 2'b01,
    CMD_ANY_WRITE = 2'b10,
    CMD_ONETIME_PROGRAM = 2'b11
  } cmd_kind_type;

endpackage

// ==== design/bit_sync.sv ====
`timescale 1ns/100ps

module bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_en,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage_one;

  // ****************************************************************
  // Two flip-flops per bit; the first is read only by the second
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : gen_bit
      always_ff @(posedge i_clk or negedge i_arst_n)
      begin
        if (!i_arst_n)
        begin
          stage_one[g] <= 1'b0;
          o_sync[g] <= 1'b0;
        end
        else if (i_en)
        begin
          stage_one[g] <= i_async[g];
          o_sync[g] <= stage_one[g];
        end
      end
    end
  endgenerate

endmodule

// ==== design/spi_cmd_link.sv ====
`timescale 1ns/100ps
`include "flash_volatile_config_lock_regs.svh"

module spi_cmd_link (
  input wire logic i_sclk,
  input wire logic i_arst_n,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic [7:0] i_snap_val,
  input wire logic i_snap_req,
  output logic o_snap_ack,
  output logic o_ev_toggle,
  output flash_cfg_pkg::cmd_kind_type o_ev_kind,
  output logic [23:0] o_ev_addr,
  output logic [7:0] o_ev_sr,
  output logic [7:0] o_ev_cr
);
  import flash_cfg_pkg::*;

  logic [2:0] bit_cnt;
  logic [2:0] byte_idx;
  logic [7:0] shift_in;
  logic [7:0] opcode;
  logic [23:0] addr;
  logic [7:0] first_data;
  logic [7:0] tx_byte;
  logic reading;
  logic [7:0] reg_copy;
  logic snap_req_sync;

  wire frame_rst_n = i_arst_n & ~i_cs_n;
  wire [7:0] rx_byte = {shift_in[6:0], i_mosi};
  wire byte_done = (bit_cnt == 3'h7);
  wire is_legacy_wr = (opcode == `OP_LEGACY_REGISTER_WRITE);
  wire is_any_wr = (opcode == `OP_ANY_REGISTER_WRITE);
  wire is_otp_prog = (opcode == `OP_ONETIME_AREA_PROGRAM);
  wire is_any_rd = (opcode == `OP_ANY_REGISTER_READ);
  wire addr_hits_cfg = (addr == `ADDR_CONFIG_ONE_VOLATILE);
  wire [2:0] rd_data_idx = 3'h3 + `ANY_READ_DUMMY_BYTES;
  wire start_cfg_rd = (byte_idx == 3'h0)
                    && (rx_byte == `OP_CONFIG_READ);
  wire start_any_rd = is_any_rd && (byte_idx == rd_data_idx);
  wire [7:0] any_rd_val = addr_hits_cfg ? reg_copy : 8'h00;
  wire post_legacy = is_legacy_wr && (byte_idx == 3'h2);
  wire post_addr_wr = (is_any_wr || is_otp_prog)
                    && (byte_idx == 3'h4);

  // ****************************************************************
  // Register value handed over from the system clock
  // ****************************************************************
  bit_sync #(
    .WIDTH(1)
  ) u_snap_sync (
    .i_clk(i_sclk),
    .i_arst_n(i_arst_n),
    .i_en(1'b1),
    .i_async(i_snap_req),
    .o_sync(snap_req_sync)
  );

  always_ff @(posedge i_sclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      reg_copy <= 8'h00;
      o_snap_ack <= 1'b0;
    end
    else if (snap_req_sync != o_snap_ack)
    begin
      reg_copy <= i_snap_val;
      o_snap_ack <= snap_req_sync;
    end
  end

  // ****************************************************************
  // Frame shifter, cleared while chip select is high
  // ****************************************************************
  always_ff @(posedge i_sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      bit_cnt <= 3'h0;
      byte_idx <= 3'h0;
      shift_in <= 8'h00;
      opcode <= 8'h00;
      addr <= 24'h000000;
      first_data <= 8'h00;
    end
    else
    begin
      bit_cnt <= bit_cnt + 3'h1;
      shift_in <= rx_byte;
      if (byte_done && byte_idx != 3'h7)
        byte_idx <= byte_idx + 3'h1;
      if (byte_done && byte_idx == 3'h0)
        opcode <= rx_byte;
      if (byte_done && byte_idx >= 3'h1 && byte_idx <= 3'h3)
        addr <= {addr[15:0], rx_byte};
      if (byte_done && byte_idx == 3'h1)
        first_data <= rx_byte;
    end
  end

  // ****************************************************************
  // Read answers
  // ****************************************************************
  // config and any-register read
  always_ff @(posedge i_sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      tx_byte <= 8'h00;
      reading <= 1'b0;
    end
    else if (byte_done)
    begin
      if (start_cfg_rd || (reading && !is_any_rd))
      begin
        tx_byte <= reg_copy;
        reading <= 1'b1;
      end
      else if (start_any_rd || (reading && is_any_rd))
      begin
        tx_byte <= any_rd_val;
        reading <= 1'b1;
      end
    end
  end

  always_ff @(negedge i_sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      o_miso <= 1'b0;
      o_miso_oe <= 1'b0;
    end
    else
    begin
      o_miso <= tx_byte[~bit_cnt];
      o_miso_oe <= reading;
    end
  end

  // ****************************************************************
  // Completed write commands, posted by toggle
  // ****************************************************************
  always_ff @(posedge i_sclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_ev_toggle <= 1'b0;
      o_ev_kind <= CMD_NONE;
      o_ev_addr <= 24'h000000;
      o_ev_sr <= 8'h00;
      o_ev_cr <= 8'h00;
    end
    else if (!i_cs_n && byte_done && (post_legacy || post_addr_wr))
    begin
      o_ev_toggle <= ~o_ev_toggle;
      o_ev_addr <= addr;
      o_ev_cr <= rx_byte;
      o_ev_sr <= first_data;
      if (post_legacy)
        o_ev_kind <= CMD_LEGACY_WRITE;
      else if (is_any_wr)
        o_ev_kind <= CMD_ANY_WRITE;
      else
        o_ev_kind <= CMD_ONETIME_PROGRAM;
    end
  end

endmodule

// ==== design/flash_volatile_config_lock.sv ====
`timescale 1ns/100ps
`include "flash_volatile_config_lock_regs.svh"

module flash_volatile_config_lock (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic i_wp_n,
  input wire logic i_io3_reset_n,
  input wire logic i_protect_origin_otp,
  input wire logic i_protect_select_otp,
  input wire logic i_param_location_otp,
  input wire logic i_freeze_default,
  input wire logic i_four_wide_instruction_mode,
  input wire logic i_soft_reset,
  input wire logic i_hw_reset,
  input wire logic i_clear_prog_error,
  output logic [7:0] o_config_one_volatile,
  output logic o_wide_data_default_bit,
  output logic o_status_write_disable_nv,
  output logic [2:0] o_bp_nonvolatile,
  output logic [2:0] o_bp_volatile,
  output logic o_prog_error,
  output logic o_otp_prog_start,
  output logic [23:0] o_otp_prog_addr,
  output logic o_protect_locked,
  output logic o_quad_width,
  output logic o_wp_n_internal,
  output logic o_io3_reset_req
);
  import flash_cfg_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic protect_origin_shadow;
  logic protect_select_shadow;
  logic param_location_shadow;
  logic quad;
  logic freeze;
  logic init_done;
  logic ev_seen;
  logic [7:0] snap_val;
  logic snap_req;
  logic ev_toggle;
  cmd_kind_type ev_kind;
  logic [23:0] ev_addr;
  logic [7:0] ev_sr;
  logic [7:0] ev_cr;
  logic snap_ack;
  logic ev_sync;
  logic ack_sync;
  logic wp_sync;
  logic io3_sync;
  logic cs_sync;

  // Refuses a clear of a quad bit while four-wide instruction mode is on
  function automatic logic next_quad_value(input logic cur,
                                           input logic req,
                                           input logic four_wide);
    next_quad_value = four_wide ? (cur | req) : req;
  endfunction

  // ****************************************************************
  // Link side and crossings
  // ****************************************************************
  spi_cmd_link u_link (
    .i_sclk(i_sclk),
    .i_arst_n(i_arst_n),
    .i_cs_n(i_cs_n),
    .i_mosi(i_mosi),
    .o_miso(o_miso),
    .o_miso_oe(o_miso_oe),
    .i_snap_val(snap_val),
    .i_snap_req(snap_req),
    .o_snap_ack(snap_ack),
    .o_ev_toggle(ev_toggle),
    .o_ev_kind(ev_kind),
    .o_ev_addr(ev_addr),
    .o_ev_sr(ev_sr),
    .o_ev_cr(ev_cr)
  );

  bit_sync #(
    .WIDTH(5)
  ) u_sync (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_en(i_clk_en),
    .i_async({ev_toggle, snap_ack, i_wp_n, i_io3_reset_n, i_cs_n}),
    .o_sync({ev_sync, ack_sync, wp_sync, io3_sync, cs_sync})
  );

  // ****************************************************************
  // Command decode
  // ****************************************************************
  wire ev_fire = (ev_sync != ev_seen);
  wire legacy_wr = ev_fire && (ev_kind == CMD_LEGACY_WRITE);
  wire any_wr = ev_fire && (ev_kind == CMD_ANY_WRITE);
  wire otp_prog = ev_fire && (ev_kind == CMD_ONETIME_PROGRAM);
  wire hit_sts_nv = any_wr && (ev_addr == `ADDR_STATUS_ONE_NONVOLATILE);
  wire hit_sts_v = any_wr && (ev_addr == `ADDR_STATUS_ONE_VOLATILE);
  wire hit_cfg_nv = any_wr && (ev_addr == `ADDR_CONFIG_ONE_NONVOLATILE);
  wire hit_cfg_v = any_wr && (ev_addr == `ADDR_CONFIG_ONE_VOLATILE);
  wire [7:0] sts_data = legacy_wr ? ev_sr : ev_cr;
  wire [2:0] bp_data = sts_data[`STS_BP_HI:`STS_BP_LO];

  wire bp_nv_we = !freeze
                && ((legacy_wr && !protect_select_shadow) || hit_sts_nv);
  wire bp_v_we = !freeze && (legacy_wr || hit_sts_v || bp_nv_we);
  wire srwd_we = legacy_wr || hit_sts_nv;
  // legacy write hits both quad bits
  wire wide_data_default_bit_we = legacy_wr || hit_cfg_nv;
  wire quad_we = legacy_wr || hit_cfg_v;
  wire freeze_set = !freeze && (legacy_wr || hit_cfg_v)
                  && ev_cr[`CFG_FREEZE];
  wire otp_in_area = (ev_addr <= `ONETIME_AREA_LAST);
  wire otp_fail = otp_prog && otp_in_area && freeze;
  wire otp_ok = otp_prog && otp_in_area && !freeze;

  wire next_wide_data_default_bit = next_quad_value(o_wide_data_default_bit,
                                      ev_cr[`CFG_QUAD],
                                      i_four_wide_instruction_mode);
  wire next_quad = next_quad_value(quad, ev_cr[`CFG_QUAD],
                                   i_four_wide_instruction_mode);

  wire [7:0] cfg_now = {2'b00, protect_origin_shadow, 1'b0,
                        protect_select_shadow, param_location_shadow,
                        quad, freeze};

  assign o_config_one_volatile = cfg_now;
  assign o_quad_width = quad;
  assign o_protect_locked = freeze;

  // ****************************************************************
  // One-time shadows
  // ****************************************************************
  // shadows track one-time bits
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      protect_origin_shadow <= 1'b0;
      protect_select_shadow <= 1'b0;
      param_location_shadow <= 1'b0;
    end
    else if (i_clk_en)
    begin
      protect_origin_shadow <= i_protect_origin_otp;
      protect_select_shadow <= i_protect_select_otp;
      param_location_shadow <= i_param_location_otp;
    end
  end

  // ****************************************************************
  // Freeze and quad
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      init_done <= 1'b0;
      freeze <= 1'b0;
      quad <= `WIDE_DEFAULT_RST;
    end
    else if (i_clk_en)
    begin
      init_done <= 1'b1;
      if (!init_done || i_hw_reset)
      begin
        freeze <= i_freeze_default;
        quad <= o_wide_data_default_bit;
      end
      else if (i_soft_reset)
        quad <= o_wide_data_default_bit;
      else
      begin
        if (freeze_set)
          freeze <= 1'b1;
        if (quad_we)
          quad <= legacy_wr ? next_wide_data_default_bit : next_quad;
      end
    end
  end

  // ****************************************************************
  // Nonvolatile and status bits
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_wide_data_default_bit <= `WIDE_DEFAULT_RST;
      o_status_write_disable_nv <= `WRITE_DISABLE_RST;
      o_bp_nonvolatile <= `BP_RST;
      o_bp_volatile <= `BP_RST;
    end
    else if (i_clk_en)
    begin
      if (wide_data_default_bit_we)
        o_wide_data_default_bit <= next_wide_data_default_bit;
      if (srwd_we)
        o_status_write_disable_nv <= sts_data[`STS_WRITE_DISABLE];
      if (bp_nv_we)
        o_bp_nonvolatile <= bp_data;
      if (bp_v_we)
        o_bp_volatile <= bp_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_prog_error <= 1'b0;
      o_otp_prog_start <= 1'b0;
      o_otp_prog_addr <= 24'h000000;
    end
    else if (i_clk_en)
    begin
      if (otp_fail)
        o_prog_error <= 1'b1;
      else if (i_clear_prog_error)
        o_prog_error <= 1'b0;
      o_otp_prog_start <= otp_ok;
      if (otp_ok)
        o_otp_prog_addr <= ev_addr;
    end
  end

  // ****************************************************************
  // Event bookkeeping and register hand-over to the link
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ev_seen <= 1'b0;
      snap_val <= 8'h00;
      snap_req <= 1'b0;
    end
    else if (i_clk_en)
    begin
      ev_seen <= ev_sync;
      if (snap_req == ack_sync && snap_val != cfg_now)
      begin
        snap_val <= cfg_now;
        snap_req <= ~snap_req;
      end
    end
  end

  // ****************************************************************
  // Pin roles
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_wp_n_internal <= 1'b1;
      o_io3_reset_req <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_wp_n_internal <= quad | wp_sync;
      o_io3_reset_req <= quad & cs_sync & ~io3_sync;
    end
  end

endmodule

// ==== bench/flash_volatile_config_lock_asserts.sv ====
`timescale 1ns/100ps

module cfg_lock_checker (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  input wire logic i_protect_origin_otp,
  input wire logic i_protect_select_otp,
  input wire logic i_param_location_otp,
  input wire logic i_four_wide_instruction_mode,
  input wire logic i_soft_reset,
  input wire logic i_hw_reset,
  input wire logic [7:0] o_config_one_volatile,
  input wire logic [2:0] o_bp_nonvolatile,
  input wire logic [2:0] o_bp_volatile,
  input wire logic o_prog_error,
  input wire logic o_otp_prog_start,
  input wire logic [23:0] o_otp_prog_addr,
  input wire logic o_protect_locked,
  input wire logic o_quad_width,
  input wire logic o_wp_n_internal,
  input wire logic o_io3_reset_req
);
  // ****************************************************************
  // Register bank checks
  // ****************************************************************
  logic [2:0] otp_bits;
  logic [2:0] shadow_bits;
  assign otp_bits = {i_protect_origin_otp, i_protect_select_otp,
                     i_param_location_otp};
  assign shadow_bits = {o_config_one_volatile[5], o_config_one_volatile[3],
                        o_config_one_volatile[2]};

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  reserved_zero_a: assert property (
    o_config_one_volatile[7:6] == 2'h0 && o_config_one_volatile[4] == 1'h0)
    else $error("reserved config bits not zero");
  shadow_track_a: assert property (
    (i_clk_en && $stable(otp_bits))[*3] |-> shadow_bits == otp_bits)
    else $error("shadow bits do not follow one-time bits");
  otp_locked_a: assert property (
    $past(o_protect_locked) |-> !o_otp_prog_start)
    else $error("one-time program started while frozen");
  wp_forced_a: assert property (
    (o_quad_width && i_clk_en)[*2] |-> o_wp_n_internal)
    else $error("write protect not inactive in quad mode");
  io3_reset_a: assert property (
    o_io3_reset_req |-> $past(o_quad_width))
    else $error("io3 reset request without quad mode");
  freeze_sticky_a: assert property (
    $past(o_protect_locked) && !$past(i_hw_reset) |-> o_protect_locked)
    else $error("freeze cleared without hardware reset");
  bp_locked_a: assert property (
    $past(o_protect_locked) |->
      $stable(o_bp_volatile) && $stable(o_bp_nonvolatile))
    else $error("protection bits changed while frozen");
  error_cause_a: assert property (
    $rose(o_prog_error) |-> $past(o_protect_locked))
    else $error("program error raised while unfrozen");
  start_ok_a: assert property (
    o_otp_prog_start |-> !$past(o_protect_locked) &&
      o_otp_prog_addr <= 24'h0003FF ##1 !o_otp_prog_start)
    else $error("bad one-time program start");
  quad_guard_a: assert property (
    $past(i_four_wide_instruction_mode) && $past(o_quad_width) &&
      !$past(i_soft_reset) && !$past(i_hw_reset) |-> o_quad_width)
    else $error("quad cleared in four-wide mode");

  cover property (o_otp_prog_start);
  cover property ($rose(o_prog_error));
  cover property ($rose(o_protect_locked) && o_quad_width);
endmodule

// ==== bench/spi_host_model.sv ====
`timescale 1ns/100ps

module spi_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi,
  input wire logic i_miso,
  input wire logic i_miso_oe
);
  // ****************************************************************
  // Serial frames, mode 0, clock idle low between frames
  // ****************************************************************
  initial
  begin
    o_sclk = 1'h0;
    o_cs_n = 1'h1;
    o_mosi = 1'h0;
  end

  task automatic frame(input logic [47:0] bits, input int nbits,
                       input bit rd, output logic [7:0] q);
    q = 8'h00;
    o_cs_n = 1'h0;
    for (int i = 0; i < nbits + (rd ? 8 : 0); i++)
    begin
      o_mosi = (i < nbits) ? bits[47-i] : ~o_mosi;
      #7.5 o_sclk = 1'h1;
      if (i >= nbits)
        q = {q[6:0], i_miso_oe ? i_miso : 1'hX};
      #7.5 o_sclk = 1'h0;
    end
    #7.5 o_cs_n = 1'h1;
    o_mosi = ~o_mosi;
  endtask
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/100ps
`include "flash_volatile_config_lock_regs.svh"

module tb_top;
  import flash_cfg_pkg::*;
  logic i_clk, i_arst_n, i_clk_en, sclk, cs_n, mosi, miso, miso_oe;
  logic i_wp_n, i_io3_reset_n, org, sel, prm, i_freeze_default;
  logic four, i_soft_reset, i_hw_reset, i_clear_prog_error;
  logic [7:0] cfg;
  logic wdef, srwd, perr, start, locked, quad, wp_int, io3_req;
  logic [2:0] bp_nv, bp_v;
  logic [23:0] paddr, seen_addr;
  logic seen_start;
  int n_mismatch, n_tests, cyc;

  flash_volatile_config_lock flash_volatile_config_lock_inst (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_clk_en(i_clk_en),
    .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi), .o_miso(miso),
    .o_miso_oe(miso_oe), .i_wp_n(i_wp_n), .i_io3_reset_n(i_io3_reset_n),
    .i_protect_origin_otp(org), .i_protect_select_otp(sel),
    .i_param_location_otp(prm), .i_freeze_default(i_freeze_default),
    .i_four_wide_instruction_mode(four), .i_soft_reset(i_soft_reset),
    .i_hw_reset(i_hw_reset), .i_clear_prog_error(i_clear_prog_error),
    .o_config_one_volatile(cfg), .o_wide_data_default_bit(wdef),
    .o_status_write_disable_nv(srwd), .o_bp_nonvolatile(bp_nv),
    .o_bp_volatile(bp_v), .o_prog_error(perr), .o_otp_prog_start(start),
    .o_otp_prog_addr(paddr), .o_protect_locked(locked),
    .o_quad_width(quad), .o_wp_n_internal(wp_int),
    .o_io3_reset_req(io3_req));

  spi_host_model spi_host_model_inst (.o_sclk(sclk), .o_cs_n(cs_n),
    .o_mosi(mosi), .i_miso(miso), .i_miso_oe(miso_oe));

  // ****************************************************************
  // Clock, watchers and access tasks
  // ****************************************************************
  always #5 i_clk = ~i_clk;

  always @(posedge i_clk)
  begin
    cyc++;
    if (start)
    begin
      seen_start <= 1'h1;
      seen_addr <= paddr;
    end
    if (cyc == 20000)
    begin
      n_mismatch++;
      tally_and_finish;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [23:0] e,
                     input logic [23:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic xfer(input logic [47:0] b, input int n, input bit r,
                      input logic [7:0] e);
    logic [7:0] q;
    spi_host_model_inst.frame(b, n, r, q);
    if (r)
      chk("read_byte", {16'h0000, e}, {16'h0000, q});
    tick(8);
  endtask

  task automatic wr_leg(input logic [7:0] s, input logic [7:0] c);
    xfer({`OP_LEGACY_REGISTER_WRITE, s, c, 24'h000000}, 24, 0, 8'h00);
  endtask

  task automatic wr_any(input logic [23:0] a, input logic [7:0] d);
    xfer({`OP_ANY_REGISTER_WRITE, a, d, 8'h00}, 40, 0, 8'h00);
  endtask

  task automatic rd_any(input logic [23:0] a, input logic [7:0] e);
    xfer({`OP_ANY_REGISTER_READ, a, 16'h0000}, 40, 1, e);
  endtask

  task automatic otp(input logic [23:0] a);
    seen_start = 1'h0;
    xfer({`OP_ONETIME_AREA_PROGRAM, a, 16'hA500}, 40, 0, 8'h00);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    i_clk = 1'h0;
    i_arst_n = 1'h0;
    i_clk_en = 1'h1;
    i_wp_n = 1'h0;
    i_io3_reset_n = 1'h1;
    org = 1'h1;
    sel = 1'h0;
    prm = 1'h1;
    i_freeze_default = 1'h0;
    four = 1'h0;
    i_soft_reset = 1'h0;
    i_hw_reset = 1'h0;
    i_clear_prog_error = 1'h0;
    seen_start = 1'h0;
    tick(10);
    i_arst_n = 1'h1;
    tick(4);
    xfer({`OP_CONFIG_READ, 40'h0}, 8, 1, 8'h24);
    chk("wp_internal", 1'h0, wp_int);
    org = 1'h0;
    sel = 1'h1;
    prm = 1'h0;
    tick(4);
    rd_any(`ADDR_CONFIG_ONE_VOLATILE, 8'h08);
    $display("test shadows done");
    wr_leg(8'h1C, 8'hC2);
    chk("quad", 1'h1, quad);
    chk("quad_default", 1'h1, wdef);
    chk("bp_volatile", 3'h7, bp_v);
    chk("bp_nonvolatile", 3'h0, bp_nv);
    xfer({`OP_CONFIG_READ, 40'h0}, 8, 1, 8'h0A);
    chk("wp_internal", 1'h1, wp_int);
    i_io3_reset_n = 1'h0;
    tick(6);
    chk("io3_reset", 1'h1, io3_req);
    i_io3_reset_n = 1'h1;
    tick(6);
    chk("io3_reset", 1'h0, io3_req);
    $display("test legacy write done");
    four = 1'h1;
    tick(2);
    wr_any(`ADDR_CONFIG_ONE_VOLATILE, 8'h00);
    chk("quad", 1'h1, quad);
    four = 1'h0;
    tick(2);
    wr_any(`ADDR_CONFIG_ONE_VOLATILE, 8'h00);
    chk("quad", 1'h0, quad);
    chk("quad_default", 1'h1, wdef);
    wr_any(`ADDR_CONFIG_ONE_NONVOLATILE, 8'h00);
    chk("quad_default", 1'h0, wdef);
    $display("test quad control done");
    otp(24'h0003FF);
    chk("prog_start", 1'h1, seen_start);
    chk("prog_addr", 24'h0003FF, seen_addr);
    otp(24'h000400);
    chk("prog_start", 1'h0, seen_start);
    $display("test one-time program done");
    wr_any(`ADDR_CONFIG_ONE_VOLATILE, 8'h03);
    chk("freeze", 1'h1, locked);
    chk("quad", 1'h1, quad);
    wr_leg(8'h80, 8'h02);
    chk("write_disable", 1'h1, srwd);
    chk("quad_default", 1'h1, wdef);
    chk("bp_volatile", 3'h7, bp_v);
    chk("prog_error", 1'h0, perr);
    wr_any(`ADDR_CONFIG_ONE_VOLATILE, 8'h00);
    chk("quad", 1'h0, quad);
    chk("freeze", 1'h1, locked);
    wr_any(`ADDR_STATUS_ONE_VOLATILE, 8'h00);
    chk("bp_volatile", 3'h7, bp_v);
    wr_any(`ADDR_STATUS_ONE_NONVOLATILE, 8'h1C);
    chk("bp_nonvolatile", 3'h0, bp_nv);
    otp(24'h000010);
    chk("prog_error", 1'h1, perr);
    chk("prog_start", 1'h0, seen_start);
    i_clear_prog_error = 1'h1;
    tick(1);
    i_clear_prog_error = 1'h0;
    tick(2);
    chk("prog_error", 1'h0, perr);
    $display("test freeze lock done");
    i_soft_reset = 1'h1;
    tick(1);
    i_soft_reset = 1'h0;
    tick(2);
    chk("freeze", 1'h1, locked);
    chk("quad", 1'h1, quad);
    i_hw_reset = 1'h1;
    tick(1);
    i_hw_reset = 1'h0;
    tick(2);
    chk("freeze", 1'h0, locked);
    i_freeze_default = 1'h1;
    i_arst_n = 1'h0;
    tick(10);
    i_arst_n = 1'h1;
    tick(4);
    chk("freeze", 1'h1, locked);
    chk("quad", 1'h0, quad);
    xfer({`OP_CONFIG_READ, 40'h0}, 8, 1, 8'h09);
    chk("config", 8'h09, cfg);
    i_clk_en = 1'h0;
    org = 1'h1;
    tick(4);
    chk("config", 8'h09, cfg);
    i_clk_en = 1'h1;
    tick(4);
    chk("config", 8'h29, cfg);
    $display("test resets done");
    tally_and_finish;
  end
endmodule

bind flash_volatile_config_lock cfg_lock_checker cfg_lock_checker_inst (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_clk_en(i_clk_en),
  .i_protect_origin_otp(i_protect_origin_otp),
  .i_protect_select_otp(i_protect_select_otp),
  .i_param_location_otp(i_param_location_otp),
  .i_four_wide_instruction_mode(i_four_wide_instruction_mode),
  .i_soft_reset(i_soft_reset), .i_hw_reset(i_hw_reset),
  .o_config_one_volatile(o_config_one_volatile),
  .o_bp_nonvolatile(o_bp_nonvolatile), .o_bp_volatile(o_bp_volatile),
  .o_prog_error(o_prog_error), .o_otp_prog_start(o_otp_prog_start),
  .o_otp_prog_addr(o_otp_prog_addr), .o_protect_locked(o_protect_locked),
  .o_quad_width(o_quad_width), .o_wp_n_internal(o_wp_n_internal),
  .o_io3_reset_req(o_io3_reset_req));
